/* File: hdl/ialm_pkg.sv */
// Package: operation classes, shift kinds, latencies and the issue/result carriers
package ialm_pkg;

  // ---------------------------------------------------------------------------
  // Operation classes
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OPC_COPY,        // Register copy and inverted copy
    OPC_ARITH,       // Logical, add, subtract, carry, compare and test
    OPC_SAT_HALF,    // Saturating and halving packed forms
    OPC_SAT_DBL,     // Doubling saturate and single-value saturate
    OPC_PACK,        // Pack halfwords
    OPC_PACKED_MOD,  // Dual saturate and plain modular packed forms
    OPC_EXT_ACC,     // Extend then accumulate
    OPC_EXT,         // Plain extend
    OPC_BITFIELD,    // Bit-field clear, insert, extract
    OPC_MISC,        // Zero count, wide moves, reversals, status read
    OPC_DIVIDE,      // Signed and unsigned divide
    OPC_SR_WRITE     // Status-register write
  } ialm_opclass_t;

  typedef enum logic [1:0] {
    SHK_NONE,
    SHK_CONST,
    SHK_REG
  } ialm_shift_t;

  typedef enum logic [1:0] {
    DOP_ADD,
    DOP_SUB,
    DOP_AND,
    DOP_OR
  } ialm_aluop_t;

  // ---------------------------------------------------------------------------
  // Latencies in cycles
  // ---------------------------------------------------------------------------
  localparam logic [4:0] LAT_ONE   = 5'h01;
  localparam logic [4:0] LAT_TWO   = 5'h02;
  localparam logic [4:0] LAT_THREE = 5'h03;
  localparam logic [4:0] DIV_MIN   = 5'h04;
  localparam logic [4:0] DIV_MAX   = 5'h10;
  localparam logic [4:0] LAT_RST   = 5'h00;

  // Issue request from the issue stage
  typedef struct packed {
    ialm_opclass_t opclass;
    ialm_shift_t   shift;
    ialm_aluop_t   aluop;
    logic          mode_change;  // Status write touching mode or control bits
    logic [31:0]   op_a;
    logic [31:0]   op_b;
    logic [4:0]    shamt;
  } ialm_req_t;

  // Result returned to the write-back stage
  typedef struct packed {
    logic [31:0] data;
    logic [4:0]  latency;
  } ialm_rsp_t;

endpackage

/* File: hdl/ialm_top.sv */
// Integer execution datapath with class- and shift-dependent result latency
`timescale 1ns/1ps
// Functional notes
// - Copy: 1 cycle, register shift 2
// - Arith/logic: 1, constant shift 2, register 3
// - Saturating and halving packed ops: 2 cycles
// - Doubling saturate, single saturate: 3 cycles
// - Dual saturate, modular packed ops: 1 cycle
// - Extend then accumulate: 3 cycles
// - Plain extend: 2 cycles
// - Bit-field clear/insert/extract: 2 cycles
// - Zero count, moves, reversals, status read: 1
// - Divide: 4 to 16 cycles, data dependent
// - Plain status write 1; mode change serializes
module ialm_top (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire logic               req_valid_i,
  input  wire ialm_pkg::ialm_req_t req_i,
  output logic                    req_ready_o,
  output logic                    rsp_valid_o,
  output ialm_pkg::ialm_rsp_t     rsp_o,
  output logic                    serialize_o,
  output logic                    busy_o
);

  // ---------------------------------------------------------------------------
  // Latency selection
  // ---------------------------------------------------------------------------
  logic [4:0]  nxt_lat;
  logic [31:0] nxt_data;
  logic [4:0]  div_lat;
  logic [4:0]  lz_a;

  // Leading zeros of the dividend pick the divide time: bigger values take longer
  always_comb begin
    lz_a = 5'h1f;
    for (int i = 0; i < 32; i++) begin
      if (req_i.op_a[i]) begin
        lz_a = 5'(31 - i);
      end
    end
    if (req_i.op_a == 32'h0000_0000) begin
      div_lat = ialm_pkg::DIV_MIN;
    end else begin
      div_lat = ialm_pkg::DIV_MAX - 5'(lz_a[4:1] > 4'hc ? 4'hc : lz_a[4:1]);
    end
  end

  // Class and shift kind to cycles; classes without shifted forms ignore shift
  always_comb begin
    unique case (req_i.opclass)
      ialm_pkg::OPC_COPY: begin
        nxt_lat = (req_i.shift == ialm_pkg::SHK_REG) ? ialm_pkg::LAT_TWO : ialm_pkg::LAT_ONE;
      end
      ialm_pkg::OPC_ARITH: begin
        unique case (req_i.shift)
          ialm_pkg::SHK_NONE:  nxt_lat = ialm_pkg::LAT_ONE;
          ialm_pkg::SHK_CONST: nxt_lat = ialm_pkg::LAT_TWO;
          default:             nxt_lat = ialm_pkg::LAT_THREE;
        endcase
      end
      ialm_pkg::OPC_SAT_HALF:   nxt_lat = ialm_pkg::LAT_TWO;
      ialm_pkg::OPC_SAT_DBL:    nxt_lat = ialm_pkg::LAT_THREE;
      ialm_pkg::OPC_PACK: begin
        nxt_lat = (req_i.shift == ialm_pkg::SHK_CONST) ? ialm_pkg::LAT_TWO : ialm_pkg::LAT_ONE;
      end
      ialm_pkg::OPC_PACKED_MOD: nxt_lat = ialm_pkg::LAT_ONE;
      ialm_pkg::OPC_EXT_ACC:    nxt_lat = ialm_pkg::LAT_THREE;
      ialm_pkg::OPC_EXT:        nxt_lat = ialm_pkg::LAT_TWO;
      ialm_pkg::OPC_BITFIELD:   nxt_lat = ialm_pkg::LAT_TWO;
      ialm_pkg::OPC_MISC:       nxt_lat = ialm_pkg::LAT_ONE;
      ialm_pkg::OPC_DIVIDE:     nxt_lat = div_lat;
      ialm_pkg::OPC_SR_WRITE:   nxt_lat = ialm_pkg::LAT_ONE;
      default:                  nxt_lat = ialm_pkg::LAT_ONE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Result value: a small representative datapath
  // ---------------------------------------------------------------------------
  logic [31:0] opb_sh;

  // Second operand shift; only copy, arith and pack take it
  always_comb begin
    opb_sh = req_i.op_b;
    if (req_i.shift != ialm_pkg::SHK_NONE &&
        (req_i.opclass == ialm_pkg::OPC_COPY || req_i.opclass == ialm_pkg::OPC_ARITH ||
         req_i.opclass == ialm_pkg::OPC_PACK)) begin
      opb_sh = req_i.op_b << req_i.shamt;
    end
  end

  // Operation result
  always_comb begin
    unique case (req_i.aluop)
      ialm_pkg::DOP_ADD: nxt_data = req_i.op_a + opb_sh;
      ialm_pkg::DOP_SUB: nxt_data = req_i.op_a - opb_sh;
      ialm_pkg::DOP_AND: nxt_data = req_i.op_a & opb_sh;
      default:           nxt_data = req_i.op_a | opb_sh;
    endcase
    if (req_i.opclass == ialm_pkg::OPC_COPY) begin
      nxt_data = opb_sh;
    end
  end

  // ---------------------------------------------------------------------------
  // Countdown; one operation in flight, so a long divide stalls issue
  // ---------------------------------------------------------------------------
  logic [4:0]  cnt_ff;
  logic [4:0]  lat_ff;
  logic [31:0] data_ff;
  logic        rsp_valid_ff;
  logic        ser_ff;
  logic        take;

  assign take        = req_valid_i && req_ready_o;
  assign req_ready_o = (cnt_ff == 5'h00) && !rst_i;
  assign busy_o      = (cnt_ff != 5'h00);

  // Counter and captured result
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_ff  <= 5'h00;
      lat_ff  <= ialm_pkg::LAT_RST;
      data_ff <= 32'h0000_0000;
    end else if (take) begin
      cnt_ff  <= nxt_lat - 5'h01;
      lat_ff  <= nxt_lat;
      data_ff <= nxt_data;
    end else if (cnt_ff != 5'h00) begin
      cnt_ff <= cnt_ff - 5'h01;
    end
  end

  // Result strobe: latency N means valid N cycles after the take edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= (take && nxt_lat == ialm_pkg::LAT_ONE) || (cnt_ff == 5'h01);
    end
  end

  // Mode-changing status write is flagged for the serializing path
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ser_ff <= 1'b0;
    end else begin
      ser_ff <= take && req_i.opclass == ialm_pkg::OPC_SR_WRITE && req_i.mode_change;
    end
  end

  assign rsp_valid_o   = rsp_valid_ff;
  assign rsp_o.data    = data_ff;
  assign rsp_o.latency = lat_ff;
  assign serialize_o   = ser_ff;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_arith_reg_three: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_ARITH && req_i.shift == ialm_pkg::SHK_REG
    |-> ##1 !rsp_valid_o ##1 !rsp_valid_o ##1 rsp_valid_o)
    else $error("arith register shift not 3 cycles");
  a_copy_reg_two: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_COPY && req_i.shift == ialm_pkg::SHK_REG
    |-> ##2 rsp_valid_o && rsp_o.latency == 5'h02)
    else $error("copy register shift not 2 cycles");
  a_sat_half_two: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_SAT_HALF |-> ##1 !rsp_valid_o ##1 rsp_valid_o)
    else $error("saturating op not 2 cycles");
  a_sat_dbl_three: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_SAT_DBL |-> ##3 rsp_valid_o && rsp_o.latency == 5'h03)
    else $error("doubling saturate not 3 cycles");
  a_packed_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_PACKED_MOD |-> ##1 rsp_valid_o)
    else $error("packed modular op not 1 cycle");
  a_ext_acc_three: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_EXT_ACC |-> ##3 rsp_valid_o && $past(!rsp_valid_o))
    else $error("extend accumulate not 3 cycles");
  a_ext_two: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_EXT |-> ##2 rsp_valid_o && rsp_o.latency == 5'h02)
    else $error("extend not 2 cycles");
  a_bitfield_two: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_BITFIELD |-> ##2 rsp_valid_o)
    else $error("bit-field op not 2 cycles");
  a_misc_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_MISC |-> ##1 rsp_valid_o && rsp_o.latency == 5'h01)
    else $error("misc op not 1 cycle");
  a_divide_window: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_DIVIDE |-> ##[4:16] rsp_valid_o)
    else $error("divide outside 4 to 16 cycles");
  a_sr_write_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_SR_WRITE
    |-> ##1 rsp_valid_o && serialize_o == $past(req_i.mode_change))
    else $error("status write timing or serialize flag wrong");
  a_no_shift_form: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_SAT_HALF && req_i.shift != ialm_pkg::SHK_NONE
    |-> ##2 rsp_o.latency == 5'h02)
    else $error("shift applied to class without shifted form");
  // Short forms; a pulse seen at the take edge may still belong to the previous op
  a_copy_const_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_COPY && req_i.shift != ialm_pkg::SHK_REG |-> ##1 rsp_valid_o)
    else $error("copy unshifted or constant shift not 1 cycle");
  a_arith_none_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_ARITH && req_i.shift == ialm_pkg::SHK_NONE |-> ##1 rsp_valid_o)
    else $error("arith unshifted not 1 cycle");
  a_arith_const_two: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_ARITH && req_i.shift == ialm_pkg::SHK_CONST
    |-> ##1 !rsp_valid_o ##1 rsp_valid_o)
    else $error("arith constant shift not 2 cycles");
  a_divide_field: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_DIVIDE
    |-> ##1 rsp_o.latency >= ialm_pkg::DIV_MIN && rsp_o.latency <= ialm_pkg::DIV_MAX)
    else $error("divide latency field outside 4 to 16");
  a_pack_reg_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_PACK && req_i.shift == ialm_pkg::SHK_REG |-> ##1 rsp_valid_o)
    else $error("pack with register shift given a shifted latency");
  a_ext_no_shift: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    take && req_i.opclass == ialm_pkg::OPC_EXT && req_i.shift != ialm_pkg::SHK_NONE
    |-> ##1 !rsp_valid_o ##1 rsp_valid_o)
    else $error("extend with shift not 2 cycles");

endmodule // ialm_top

/* File: tb/ialm_issue_model.sv */
// Issue-stage model that offers one request at a time and holds it until taken
`timescale 1ns/1ps
module ialm_issue_model (
  input  wire logic                 ref_clk_i,
  input  wire logic                 ready_i,
  output logic                      valid_o,
  output ialm_pkg::ialm_req_t       req_o
);
  // Idle at time zero
  initial begin
    valid_o = 1'b0;
    req_o   = '0;
  end

  // Drive on the falling edge; hold until ready is high ahead of a rising edge
  task automatic send(input ialm_pkg::ialm_req_t r, output bit ok);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    valid_o = 1'b1;
    req_o   = r;
    #1;
    while (ready_i !== 1'b1 && n < 40) begin
      @(negedge ref_clk_i);
      #1;
      n++;
    end
    ok = (n < 40);
    @(negedge ref_clk_i);
    valid_o = 1'b0;
    req_o   = ~r;  // Released lines never show the last request
  endtask
endmodule // ialm_issue_model

/* File: tb/testbench.sv */
// Self-checking bench for the integer datapath latency behaviour
`timescale 1ns/1ps
module testbench;
  logic                ref_clk_i = 1'b0;
  logic                rst_i     = 1'b1;
  logic                req_valid, req_ready, rsp_valid, serialize, busy;
  ialm_pkg::ialm_req_t req;
  ialm_pkg::ialm_rsp_t rsp;
  int                  cyc = 0;
  int                  failures = 0;
  int                  n_checks = 0;

  // ---------------------------------------------------------------------------
  // Clock, timeout, instances
  // ---------------------------------------------------------------------------
  always #4 ref_clk_i = ~ref_clk_i;

  // A hang anywhere ends the run here
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc >= 3000) begin
      failures++;
      complete_run();
    end
  end

  ialm_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid), .req_i(req),
    .req_ready_o(req_ready), .rsp_valid_o(rsp_valid), .rsp_o(rsp), .serialize_o(serialize), .busy_o(busy));
  ialm_issue_model issue_u (.ref_clk_i(ref_clk_i), .ready_i(req_ready), .valid_o(req_valid), .req_o(req));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check_eq(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Issue one operation, then time its result pulse against the expected count
  task automatic run_op(input logic [3:0] oc, input logic [1:0] sh, input logic mc,
                        input logic [31:0] a, input logic [31:0] b, input logic [4:0] n);
    ialm_pkg::ialm_req_t r;
    bit ok;
    int take;
    int i;
    logic [31:0] bx;
    r = '{ialm_pkg::ialm_opclass_t'(oc), ialm_pkg::ialm_shift_t'(sh), ialm_pkg::DOP_ADD, mc, a, b, 5'h01};
    issue_u.send(r, ok);
    take = cyc;
    check_eq("taken", {31'h0, ok}, 32'h1);
    check_eq("busy", {31'h0, busy}, {31'h0, n > 5'h01});
    check_eq("ready", {31'h0, req_ready}, {31'h0, n == 5'h01});
    check_eq("serialize", {31'h0, serialize}, {31'h0, mc});
    i = 0;
    while (rsp_valid !== 1'b1 && i < 20) begin
      @(negedge ref_clk_i);
      i++;
    end
    // Strobe seen at this falling edge is sampled by the next rising edge
    check_eq("latency cycles", cyc + 1 - take, {27'h0, n});
    check_eq("latency field", {27'h0, rsp.latency}, {27'h0, n});
    // Only copy, arith and pack shift the second operand, by the fixed amount of one
    bx = (sh != 2'h0 && (oc == 4'h0 || oc == 4'h1 || oc == 4'h4)) ? b << 1 : b;
    check_eq("data", rsp.data, (oc == 4'h0) ? bx : a + bx);
    @(negedge ref_clk_i);
    check_eq("pulse width", {31'h0, rsp_valid}, 32'h0);
  endtask

  // Table entries: class nibble, shift nibble, expected latency nibble
  task automatic run_table(input logic [11:0] t[]);
    foreach (t[k]) run_op(t[k][11:8], t[k][5:4], 1'b0, 32'h0000_1234, 32'h0000_0011, {1'b0, t[k][3:0]});
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_reset();
    repeat (8) @(negedge ref_clk_i);
    check_eq("ready in reset", {31'h0, req_ready}, 32'h0);
    check_eq("valid in reset", {31'h0, rsp_valid}, 32'h0);
    check_eq("busy in reset", {31'h0, busy}, 32'h0);
    check_eq("serialize in reset", {31'h0, serialize}, 32'h0);
    check_eq("latency in reset", {27'h0, rsp.latency}, 32'h0);
    check_eq("data in reset", rsp.data, 32'h0);
    rst_i = 1'b0;
    @(negedge ref_clk_i);
    check_eq("ready after reset", {31'h0, req_ready}, 32'h1);
  endtask

  // Shifted forms, including shifts on classes that have none
  task automatic test_shift_forms();
    run_table('{12'h001, 12'h011, 12'h022});
    run_table('{12'h101, 12'h112, 12'h123});
    run_table('{12'h222, 12'h313, 12'h521, 12'h623, 12'h812, 12'h921});
    run_table('{12'h401, 12'h412, 12'h421, 12'h712});
  endtask

  // Reset in mid-divide drops the operation and frees issue again
  task automatic test_reset_mid();
    ialm_pkg::ialm_req_t r;
    bit ok;
    r = '{ialm_pkg::OPC_DIVIDE, ialm_pkg::SHK_NONE, ialm_pkg::DOP_ADD, 1'b0, 32'h8000_0000, 32'h3, 5'h01};
    issue_u.send(r, ok);
    check_eq("busy mid divide", {31'h0, busy}, 32'h1);
    rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    check_eq("busy in reset", {31'h0, busy}, 32'h0);
    check_eq("valid in reset", {31'h0, rsp_valid}, 32'h0);
    check_eq("latency in reset", {27'h0, rsp.latency}, 32'h0);
    rst_i = 1'b0;
    @(negedge ref_clk_i);
    check_eq("ready after reset", {31'h0, req_ready}, 32'h1);
    run_op(4'h1, 2'h0, 1'b0, 32'h0000_0005, 32'h0000_0006, 5'h01);
  endtask

  task automatic test_fixed_latency();
    run_table('{12'h202, 12'h303, 12'h501, 12'h603});
    run_table('{12'h702, 12'h802, 12'h901});
  endtask

  // Divide latency shrinks as the dividend gains leading zeros
  task automatic test_divide();
    logic [31:0] a[5] = '{32'h0, 32'h1, 32'h8000_0000, 32'h0001_0000, 32'h0000_ffff};
    int lz;
    foreach (a[k]) begin
      lz = 32;
      for (int j = 31; j >= 0; j--) if (a[k][j] && lz == 32) lz = 31 - j;
      run_op(4'ha, 2'h0, 1'b0, a[k], 32'h3, 5'(16 - ((lz / 2 > 12) ? 12 : lz / 2)));
    end
  endtask

  task automatic test_status_write();
    run_op(4'hb, 2'h0, 1'b0, 32'h0, 32'h5, 5'h01);
    run_op(4'hb, 2'h0, 1'b1, 32'h0, 32'h5, 5'h01);
  endtask

  // ---------------------------------------------------------------------------
  // Sequence and verdict
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    test_reset();
    test_shift_forms();
    test_fixed_latency();
    test_divide();
    test_status_write();
    test_reset_mid();
    complete_run();
  end
endmodule // testbench
